// ==== src/cvd_ctrl.sv ====
// Two-converter start, channel and secondary connection control on AHB-Lite
// What this block does
// - Converter 2 code 11011 routes positive reference, 11101 temperature.
// - Start bit set while enabled begins conversion; hardware clears.
// - Software clearing start aborts: no result write, no flag.
// - With RC clock, wait one instruction cycle before converting.
// - Double-sample keeps start bit set until second conversion ends.
// - Converter 2 secondary bits 0..6 connect AN20..AN26.
// - Secondaries parallel to primary; pre-charge bias on both.
// - Input chosen primary and secondary acts as primary only.
// - Secondary bit forces its pin high-impedance over direction bit.
// - Secondary connections and overrides act only while enabled.
// - Sync start starts all enabled converters; reads OR of starts.
// - Bit 7 of channel control and secondary select reads zero.
// - Every reset clears all writable control bits.
// - Converter 1 secondary bits 0..6 connect AN10..AN16.
// - Trigger code 110 starts on rising pin edge, 111 on falling.
`timescale 1ns/1ns
`default_nettype none
module cvd_ctrl
  import cvd_ctrl_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic EXT_TRIGGER,
  input wire logic [6:0] PIN_DIR1_IN,
  input wire logic [6:0] PIN_DIR2_IN,
  output logic [6:0] PIN_DIR1_OUT,
  output logic [6:0] PIN_DIR2_OUT,
  output logic [1:0] ADC_POWER,
  output logic [1:0] ADC_MUX_ON,
  output logic [4:0] ADC1_MUX_CODE,
  output logic [4:0] ADC2_MUX_CODE,
  output logic [6:0] ADC1_SEC_CONNECT,
  output logic [6:0] ADC2_SEC_CONNECT,
  output logic [1:0] ADC_CONVERTING,
  output logic [1:0] ADC_BIAS_DRIVE,
  output logic [1:0] ADC_RESULT_WRITE,
  output logic [1:0] ADC_RESULT_SLOT,
  output logic [1:0] ADC_FLAG
);

  function automatic logic in_span(input logic [4:0] c,
                                   input logic [4:0] base);
    in_span = (c >= base) && (c <= 5'(base + SEC_SPAN));
  endfunction

  function automatic logic chan_valid(input logic [4:0] c,
                                      input logic [4:0] base);
    chan_valid = (c <= CH_AN2) || (c == CH_REF) || (c == CH_TEMP) ||
                 (c == CH_FVR) || in_span(c, base);
  endfunction

  function automatic logic [6:0] sec_eff(input logic [6:0] sec,
                                         input logic [4:0] c,
                                         input logic [4:0] base);
    logic [4:0] idx;
    idx = 5'(c - base);
    sec_eff = sec;
    if (in_span(c, base))
    begin
      sec_eff[idx[2:0]] = 1'b0;
    end
  endfunction

  logic [1:0][7:0] ctrl_q, sec_q, trig_q;
  logic [7:0] com_q;
  logic [1:0] go_q, ds_q, flag_q, second_q;
  conv_state_e st_q [2];
  logic [1:0][7:0] cnt_q;
  logic wr_pend_q, rd_pend_q, ready_q;
  logic [7:0] addr_q;
  logic [31:0] rdata_q;
  logic trg_s1_q, trg_s2_q, trg_s3_q;
  logic [1:0] power_q, muxon_q, conv_q, bias_q, reswr_q, slot_q;
  logic [1:0][4:0] mux_q;
  logic [1:0][6:0] secc_q, pdir_q;
  logic ap_ok, trg_rise, trg_fall, wr_com, wr_flags, wr_ds;
  logic [1:0] wr_ctrl, wr_sec, wr_trig, en, rc_sel, set_ev;
  logic [1:0] done_pulse, done_fin;
  logic [1:0][4:0] chs, base;
  logic [1:0][6:0] sec_e;
  logic [7:0] rd_c;

  assign ap_ok = HSEL && HREADY && HTRANS[1];
  assign wr_com = wr_pend_q && (addr_q == OFS_COMMON);
  assign wr_flags = wr_pend_q && (addr_q == OFS_FLAGS);
  assign wr_ds = wr_pend_q && (addr_q == OFS_DSAMPLE);
  assign trg_rise = trg_s2_q && !trg_s3_q;
  assign trg_fall = !trg_s2_q && trg_s3_q;
  assign base[0] = SEC_BASE1;
  assign base[1] = SEC_BASE2;

  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      wr_ctrl[i] = wr_pend_q && (addr_q == (i == 0 ? OFS_ADC1_CTRL
                                                   : OFS_ADC2_CTRL));
      wr_sec[i] = wr_pend_q && (addr_q == (i == 0 ? OFS_ADC1_SEC
                                                  : OFS_ADC2_SEC));
      wr_trig[i] = wr_pend_q && (addr_q == (i == 0 ? OFS_TRIG1 : OFS_TRIG2));
      en[i] = ctrl_q[i][CTRL_EN_BIT];
      chs[i] = ctrl_q[i][CTRL_CHS_MSB:CTRL_CHS_LSB];
      rc_sel[i] = com_q[CLKSEL_MSB:CLKSEL_LSB] == CLKSEL_RC;
      sec_e[i] = sec_eff(sec_q[i][SEC_MSB:0], chs[i], base[i]);
      set_ev[i] = (wr_com && HWDATA[COM_SYNC_BIT]) ||
        (trig_q[i][TRIG_MSB:TRIG_LSB] == TRIG_RISE && trg_rise) ||
        (trig_q[i][TRIG_MSB:TRIG_LSB] == TRIG_FALL && trg_fall);
      done_pulse[i] = (st_q[i] == S_CONV) && (cnt_q[i] == CONV_CYC - CNT_ONE)
                      && go_q[i] && en[i];
      done_fin[i] = done_pulse[i] && !(ds_q[i] && !second_q[i]);
    end
  end

  // Registered read data: one wait state, so a write just before lands first
  always_comb
  begin
    rd_c = REG_RST;
    case (addr_q)
      OFS_ADC1_CTRL: rd_c = {ctrl_q[0][7:2], go_q[0], ctrl_q[0][0]};
      OFS_ADC2_CTRL: rd_c = {ctrl_q[1][7:2], go_q[1], ctrl_q[1][0]};
      OFS_ADC1_SEC: rd_c = sec_q[0];
      OFS_ADC2_SEC: rd_c = sec_q[1];
      OFS_COMMON: rd_c = com_q | {5'h00, |go_q, 2'h0};
      OFS_TRIG1: rd_c = trig_q[0];
      OFS_TRIG2: rd_c = trig_q[1];
      OFS_DSAMPLE: rd_c = {6'h00, ds_q};
      OFS_FLAGS: rd_c = {6'h00, flag_q};
      default: rd_c = REG_RST;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      ready_q <= 1'b1;
      addr_q <= REG_RST;
      rdata_q <= {RD_PAD, REG_RST};
    end
    else
    begin
      wr_pend_q <= ap_ok && HWRITE;
      rd_pend_q <= ap_ok && !HWRITE;
      ready_q <= !(ap_ok && !HWRITE);
      if (ap_ok)
      begin
        addr_q <= HADDR[7:0];
      end
      if (rd_pend_q)
      begin
        rdata_q <= {RD_PAD, rd_c};
      end
    end
  end

  // Control registers; reserved bit 7 is never stored
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      ctrl_q <= '0;
      sec_q <= '0;
      trig_q <= '0;
      com_q <= REG_RST;
      ds_q <= '0;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (wr_ctrl[i])
        begin
          ctrl_q[i] <= HWDATA[7:0] & SEC_MASK & ~8'h02;
        end
        if (wr_sec[i])
        begin
          sec_q[i] <= HWDATA[7:0] & SEC_MASK;
        end
        if (wr_trig[i])
        begin
          trig_q[i] <= HWDATA[7:0] & TRIG_MASK;
        end
      end
      if (wr_com)
      begin
        com_q <= HWDATA[7:0] & COM_MASK & ~8'h04;
      end
      if (wr_ds)
      begin
        ds_q <= HWDATA[1:0];
      end
    end
  end

  // Start/done and flag; any set source beats the hardware clear
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      go_q <= '0;
      flag_q <= '0;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (wr_ctrl[i])
        begin
          go_q[i] <= HWDATA[CTRL_GO_BIT] && HWDATA[CTRL_EN_BIT];
        end
        else if (!en[i])
        begin
          go_q[i] <= 1'b0;
        end
        else if (set_ev[i])
        begin
          go_q[i] <= 1'b1;
        end
        else if (done_fin[i])
        begin
          go_q[i] <= 1'b0;
        end
        if (done_fin[i])
        begin
          flag_q[i] <= 1'b1;
        end
        else if (wr_flags && HWDATA[i])
        begin
          flag_q[i] <= 1'b0;
        end
      end
    end
  end

  // Conversion sequence; analog timing beyond this length lives outside
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      cnt_q <= '0;
      second_q <= '0;
      for (int i = 0; i < 2; i++)
      begin
        st_q[i] <= S_IDLE;
      end
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        case (st_q[i])
          S_IDLE:
          begin
            second_q[i] <= 1'b0;
            cnt_q[i] <= CNT_ZERO;
            if (go_q[i] && en[i])
            begin
              st_q[i] <= rc_sel[i] ? S_WAIT : S_CONV;
            end
          end
          S_WAIT:
          begin
            if (!go_q[i] || !en[i])
            begin
              st_q[i] <= S_IDLE;
            end
            else if (cnt_q[i] == RC_WAIT_CYC - CNT_ONE)
            begin
              st_q[i] <= S_CONV;
              cnt_q[i] <= CNT_ZERO;
            end
            else
            begin
              cnt_q[i] <= cnt_q[i] + CNT_ONE;
            end
          end
          S_CONV:
          begin
            if (!go_q[i] || !en[i])
            begin
              st_q[i] <= S_IDLE;
            end
            else if (done_pulse[i])
            begin
              cnt_q[i] <= CNT_ZERO;
              if (done_fin[i])
              begin
                st_q[i] <= S_IDLE;
              end
              else
              begin
                second_q[i] <= 1'b1;
              end
            end
            else
            begin
              cnt_q[i] <= cnt_q[i] + CNT_ONE;
            end
          end
          default: st_q[i] <= S_IDLE;
        endcase
      end
    end
  end

  // Trigger pin synchroniser and edge detect
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      trg_s1_q <= 1'b0;
      trg_s2_q <= 1'b0;
      trg_s3_q <= 1'b0;
    end
    else
    begin
      trg_s1_q <= EXT_TRIGGER;
      trg_s2_q <= trg_s1_q;
      trg_s3_q <= trg_s2_q;
    end
  end

  // Analog switch and pin outputs, registered one cycle behind the control
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      power_q <= '0;
      muxon_q <= '0;
      mux_q <= '0;
      secc_q <= '0;
      pdir_q <= '0;
      conv_q <= '0;
      bias_q <= '0;
      reswr_q <= '0;
      slot_q <= '0;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        power_q[i] <= en[i];
        muxon_q[i] <= en[i] && chan_valid(chs[i], base[i]);
        mux_q[i] <= chs[i];
        secc_q[i] <= en[i] ? sec_e[i] : 7'h00;
        pdir_q[i] <= (i == 0 ? PIN_DIR1_IN : PIN_DIR2_IN) |
                     (en[i] ? sec_e[i] : 7'h00);
        conv_q[i] <= st_q[i] == S_CONV;
        bias_q[i] <= st_q[i] == S_CONV && cnt_q[i] < PRE_CYC;
        reswr_q[i] <= done_pulse[i];
        slot_q[i] <= second_q[i];
      end
    end
  end

  assign HRDATA = rdata_q;
  assign HREADYOUT = ready_q;
  assign HRESP = 1'b0;
  assign PIN_DIR1_OUT = pdir_q[0];
  assign PIN_DIR2_OUT = pdir_q[1];
  assign ADC_POWER = power_q;
  assign ADC_MUX_ON = muxon_q;
  assign ADC1_MUX_CODE = mux_q[0];
  assign ADC2_MUX_CODE = mux_q[1];
  assign ADC1_SEC_CONNECT = secc_q[0];
  assign ADC2_SEC_CONNECT = secc_q[1];
  assign ADC_CONVERTING = conv_q;
  assign ADC_BIAS_DRIVE = bias_q;
  assign ADC_RESULT_WRITE = reswr_q;
  assign ADC_RESULT_SLOT = slot_q;
  assign ADC_FLAG = flag_q;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  property p_temp_route;
    (en[1] && chs[1] == CH_TEMP) |=> ADC_MUX_ON[1] && ADC2_MUX_CODE == CH_TEMP;
  endproperty
  a_temp_route: assert property (p_temp_route) else $error("temp");
  property p_off;
    !en[0] |=> !ADC_POWER[0] && !ADC_MUX_ON[0] && ADC1_SEC_CONNECT == 7'h00;
  endproperty
  a_off: assert property (p_off) else $error("disabled still on");
  property p_start;
    (wr_ctrl[0] && HWDATA[CTRL_GO_BIT] && HWDATA[CTRL_EN_BIT]) |=> go_q[0];
  endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_abort;
    (st_q[0] == S_CONV && !go_q[0]) |=>
      (st_q[0] == S_IDLE && !$rose(flag_q[0])) ##1 !ADC_RESULT_WRITE[0];
  endproperty
  a_abort: assert property (p_abort) else $error("abort leaked");
  property p_rc_wait;
    (st_q[0] == S_IDLE && go_q[0] && en[0] && rc_sel[0]) |=>
      (st_q[0] == S_WAIT)[*8];
  endproperty
  a_rc_wait: assert property (p_rc_wait) else $error("rc wait short");
  property p_double;
    (done_pulse[1] && ds_q[1] && !second_q[1]) |=>
      go_q[1] && second_q[1] && st_q[1] == S_CONV;
  endproperty
  a_double: assert property (p_double) else $error("double ended");
  property p_prim_wins;
    (en[1] && chs[1] == SEC_BASE2 && sec_q[1][0]) |=> !ADC2_SEC_CONNECT[0];
  endproperty
  a_prim_wins: assert property (p_prim_wins) else $error("dup sec");
  property p_hiz;
    (en[1] && sec_e[1][1]) |=> PIN_DIR2_OUT[1];
  endproperty
  a_hiz: assert property (p_hiz) else $error("no hiz");
  property p_sync;
    (wr_com && HWDATA[COM_SYNC_BIT] && en[0] && en[1] && !wr_ctrl[0])
      |=> go_q[0] && go_q[1];
  endproperty
  a_sync: assert property (p_sync) else $error("sync start");
  property p_bit7;
    (rd_pend_q && addr_q == OFS_ADC2_SEC) |=> !HRDATA[7];
  endproperty
  a_bit7: assert property (p_bit7) else $error("bit7 set");
  property p_done_flag;
    (done_fin[0] && !wr_ctrl[0] && !set_ev[0]) |=> !go_q[0] && flag_q[0];
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("done");
  property p_c_double;
    done_fin[1] && second_q[1];
  endproperty
  c_double: cover property (p_c_double);
  property p_c_abort;
    st_q[0] == S_CONV && !go_q[0];
  endproperty
  c_abort: cover property (p_c_abort);
  property p_c_trig;
    trg_fall && set_ev[1] && st_q[1] == S_IDLE;
  endproperty
  c_trig: cover property (p_c_trig);
endmodule
`default_nettype wire

// ==== src/cvd_ctrl_pkg.sv ====
// Register map, field layout and timing constants of the converter control
package cvd_ctrl_pkg;
  localparam logic [7:0] OFS_ADC1_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADC2_CTRL = 8'h04;
  localparam logic [7:0] OFS_ADC1_SEC = 8'h08;
  localparam logic [7:0] OFS_ADC2_SEC = 8'h0c;
  localparam logic [7:0] OFS_COMMON = 8'h10;
  localparam logic [7:0] OFS_TRIG1 = 8'h14;
  localparam logic [7:0] OFS_TRIG2 = 8'h18;
  localparam logic [7:0] OFS_DSAMPLE = 8'h1c;
  localparam logic [7:0] OFS_FLAGS = 8'h20;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [23:0] RD_PAD = 24'h000000;
  // Channel control: enable, start/done, primary channel code
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_GO_BIT = 1;
  localparam int CTRL_CHS_LSB = 2;
  localparam int CTRL_CHS_MSB = 6;
  localparam int SEC_MSB = 6;
  localparam logic [7:0] SEC_MASK = 8'h7f;
  // Common control: format bit 7, clock select 6:4, sync start 2, ref 1:0
  localparam logic [7:0] COM_MASK = 8'hf3;
  localparam int COM_SYNC_BIT = 2;
  localparam int CLKSEL_LSB = 4;
  localparam int CLKSEL_MSB = 6;
  localparam logic [2:0] CLKSEL_RC = 3'h7;
  localparam logic [7:0] TRIG_MASK = 8'h70;
  localparam int TRIG_LSB = 4;
  localparam int TRIG_MSB = 6;
  localparam logic [2:0] TRIG_RISE = 3'h6;
  localparam logic [2:0] TRIG_FALL = 3'h7;
  // Fixed primary channel codes
  localparam logic [4:0] CH_AN0 = 5'h00;
  localparam logic [4:0] CH_AN2 = 5'h02;
  localparam logic [4:0] CH_REF = 5'h1b;
  localparam logic [4:0] CH_TEMP = 5'h1d;
  localparam logic [4:0] CH_FVR = 5'h1f;
  localparam logic [4:0] SEC_BASE1 = 5'h0a;
  localparam logic [4:0] SEC_BASE2 = 5'h14;
  localparam logic [4:0] SEC_SPAN = 5'h06;
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int INSTR_CYCLE_NS = 125;
  localparam int CONV_TIME_NS = 1000;
  localparam int PRECHARGE_NS = 250;
  localparam logic [7:0] RC_WAIT_CYC =
    8'((INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] CONV_CYC = 8'(CONV_TIME_NS / CLK_PERIOD_NS);
  localparam logic [7:0] PRE_CYC =
    8'((PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  typedef enum logic [1:0] {S_IDLE, S_WAIT, S_CONV} conv_state_e;
endpackage

// ==== verif/cvd_adc_channel_start_control_test.sv ====
// Self-checking bench for converter start and channel control
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) \
  begin \
    samples_checked++; \
    if ((a) !== (b)) \
    begin \
      fails++; \
      $display("[ERR] %0t got %h exp %h", $time, a, b); \
    end \
  end
module cvd_adc_channel_start_control_test
  import cvd_ctrl_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic touch = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic rdy, hresp, trig;
  logic [6:0] d1i, d2i, d1o, d2o, sec1, sec2;
  logic [4:0] code1, code2;
  logic [1:0] pwr, mux, conv, bias, rwr, slot, flag;
  logic [7:0] v;
  int fails = 0;
  int samples_checked = 0;
  int cycles = 0;
  int pulses [2] = '{0, 0};
  // Result slot seen with each pulse, newest in bit 0
  logic [1:0] slot_log [2] = '{2'h0, 2'h0};

  cvd_ctrl DUT (
    .CLK(clk), .SYS_RST(rst), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(rdy), .HRDATA(hrdata), .HREADYOUT(rdy), .HRESP(hresp),
    .EXT_TRIGGER(trig), .PIN_DIR1_IN(d1i), .PIN_DIR2_IN(d2i),
    .PIN_DIR1_OUT(d1o), .PIN_DIR2_OUT(d2o), .ADC_POWER(pwr),
    .ADC_MUX_ON(mux), .ADC1_MUX_CODE(code1), .ADC2_MUX_CODE(code2),
    .ADC1_SEC_CONNECT(sec1), .ADC2_SEC_CONNECT(sec2),
    .ADC_CONVERTING(conv), .ADC_BIAS_DRIVE(bias),
    .ADC_RESULT_WRITE(rwr), .ADC_RESULT_SLOT(slot), .ADC_FLAG(flag)
  );
  electrode_pins #(.DIR1(7'h00), .DIR2(7'h01)) PINS (
    .touch(touch), .trig_pin(trig), .dir1(d1i), .dir2(d2i)
  );

  always #4 clk = ~clk;

  // Result pulses last one cycle, so count them rather than poll
  always @(posedge clk)
  begin
    cycles++;
    for (int i = 0; i < 2; i++)
      if (rwr[i] === 1'b1)
      begin
        pulses[i]++;
        slot_log[i] = {slot_log[i][0], slot[i]};
      end
    if (cycles == 20000)
    begin
      fails++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wt();
    do
      @(posedge clk);
    while (rdy !== 1'b1);
  endtask

  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wt();
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wt();
    v = hrdata[7:0];
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(a, 1'b1, d);
  endtask

  task automatic ck(input logic [7:0] a, input logic [7:0] e);
    xfer(a, 1'b0, 8'h00);
    `CHK(v, e)
  endtask

  // Polls the sync bit, which reads as the OR of both start bits
  task automatic idle();
    for (int i = 0; i < 100; i++)
    begin
      xfer(OFS_COMMON, 1'b0, 8'h00);
      if (v[COM_SYNC_BIT] === 1'b0)
        break;
    end
    `CHK(v[COM_SYNC_BIT], 1'b0)
  endtask

  task automatic t_reset();
    wr(OFS_ADC1_SEC, 8'h11);
    wr(OFS_DSAMPLE, 8'h03);
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    cyc(1);
    for (int i = 0; i <= 8; i++)
      ck(8'(4 * i), 8'h00);
    `CHK({pwr, flag}, 4'h0)
  endtask

  task automatic t_regs();
    wr(OFS_ADC1_SEC, 8'hff);
    ck(OFS_ADC1_SEC, 8'h7f);
    wr(OFS_ADC2_SEC, 8'hff);
    ck(OFS_ADC2_SEC, 8'h7f);
    wr(OFS_ADC2_CTRL, 8'h80);
    ck(OFS_ADC2_CTRL, 8'h00);
    wr(OFS_COMMON, 8'hfe);
    ck(OFS_COMMON, 8'hf2);
    wr(8'h3c, 8'hff);
    ck(8'h3c, 8'h00);
    `CHK(hresp, 1'b0)
    wr(OFS_ADC1_SEC, 8'h00);
    wr(OFS_ADC2_SEC, 8'h00);
    wr(OFS_COMMON, 8'h00);
  endtask

  task automatic t_sec();
    wr(OFS_ADC2_SEC, 8'h7f);
    cyc(3);
    `CHK({sec2, d2o}, {7'h00, 7'h01})
    wr(OFS_ADC2_CTRL, 8'h59);
    wr(OFS_ADC1_SEC, 8'h41);
    wr(OFS_ADC1_CTRL, 8'h29);
    cyc(3);
    `CHK({sec2, d2o}, {7'h7b, 7'h7b})
    `CHK({sec1, d1o}, {7'h40, 7'h40})
    `CHK(code1, SEC_BASE1)
    `CHK({pwr, mux, code2}, {4'hf, 5'h16})
    wr(OFS_ADC2_CTRL, 8'h00);
    wr(OFS_ADC1_CTRL, 8'h00);
    cyc(3);
    `CHK({pwr, mux, sec1, sec2, d2o}, {4'h0, 14'h0, 7'h01})
    wr(OFS_ADC1_SEC, 8'h00);
    wr(OFS_ADC2_SEC, 8'h00);
  endtask

  task automatic t_codes();
    logic [4:0] c [3] = '{CH_REF, CH_TEMP, 5'h1c};
    for (int i = 0; i < 3; i++)
    begin
      wr(OFS_ADC2_CTRL, {1'b0, c[i], 2'b01});
      cyc(3);
      `CHK({mux[1], code2}, {i != 2, c[i]})
    end
    wr(OFS_ADC2_CTRL, 8'h00);
  endtask

  task automatic t_conv();
    int p;
    wr(OFS_ADC1_CTRL, 8'h01);
    p = pulses[0];
    wr(OFS_ADC1_CTRL, 8'h03);
    cyc(8);
    `CHK({conv[0], bias[0]}, 2'b11)
    idle();
    cyc(3);
    `CHK(flag[0], 1'b1)
    `CHK(pulses[0] - p, 1)
    ck(OFS_FLAGS, 8'h01);
    wr(OFS_FLAGS, 8'h01);
    ck(OFS_FLAGS, 8'h00);
    wr(OFS_COMMON, {1'b0, CLKSEL_RC, 4'h0});
    wr(OFS_ADC1_CTRL, 8'h03);
    cyc(8);
    `CHK(conv[0], 1'b0)
    cyc(20);
    `CHK(conv[0], 1'b1)
    idle();
    wr(OFS_COMMON, 8'h00);
    wr(OFS_FLAGS, 8'h01);
  endtask

  task automatic t_abort();
    int p;
    p = pulses[0];
    wr(OFS_ADC1_CTRL, 8'h03);
    cyc(20);
    wr(OFS_ADC1_CTRL, 8'h01);
    cyc(150);
    `CHK({conv[0], flag[0]}, 2'b00)
    `CHK(pulses[0], p)
    ck(OFS_ADC1_CTRL, 8'h01);
  endtask

  task automatic t_double();
    int p;
    p = pulses[1];
    wr(OFS_DSAMPLE, 8'h02);
    wr(OFS_ADC2_CTRL, 8'h51);
    wr(OFS_ADC2_SEC, 8'h01);
    cyc(3);
    `CHK({sec2, d2o}, {7'h00, 7'h01})
    slot_log[1] = 2'b11;
    wr(OFS_ADC2_CTRL, 8'h53);
    cyc(140);
    ck(OFS_ADC2_CTRL, 8'h53);
    idle();
    cyc(3);
    `CHK(pulses[1] - p, 2)
    `CHK(slot_log[1], 2'b01)
    wr(OFS_ADC2_SEC, 8'h00);
    wr(OFS_DSAMPLE, 8'h00);
    wr(OFS_FLAGS, 8'h03);
  endtask

  task automatic t_sync();
    wr(OFS_COMMON, 8'h04);
    cyc(4);
    `CHK(conv, 2'b11)
    ck(OFS_COMMON, 8'h04);
    idle();
    cyc(3);
    `CHK(flag, 2'b11)
    wr(OFS_FLAGS, 8'h03);
    wr(OFS_ADC2_CTRL, 8'h50);
    wr(OFS_COMMON, 8'h04);
    cyc(4);
    `CHK(conv, 2'b01)
    idle();
  endtask

  task automatic t_trig();
    wr(OFS_ADC2_CTRL, 8'h51);
    wr(OFS_TRIG1, {1'b0, TRIG_RISE, 4'h0});
    wr(OFS_TRIG2, {1'b0, TRIG_FALL, 4'h0});
    wr(OFS_FLAGS, 8'h03);
    touch <= 1'b1;
    cyc(10);
    `CHK(conv, 2'b01)
    touch <= 1'b0;
    cyc(10);
    `CHK(conv, 2'b11)
    idle();
    wr(OFS_TRIG1, 8'h00);
    wr(OFS_TRIG2, 8'h00);
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_regs();
    t_sec();
    t_codes();
    t_conv();
    t_abort();
    t_double();
    t_sync();
    t_trig();
    t_reset();
    end_of_test();
  end
endmodule
`default_nettype wire

// ==== verif/electrode_pins.sv ====
// Pin-side model: external trigger electrode and programmed pin directions
`timescale 1ns/1ns
`default_nettype none
module electrode_pins #(
  parameter logic [6:0] DIR1 = 7'h00,
  parameter logic [6:0] DIR2 = 7'h01
)
(
  input wire logic touch,
  output logic trig_pin,
  output logic [6:0] dir1,
  output logic [6:0] dir2
);
  // Pin moves off the clock grid so the input synchroniser is exercised
  assign #3 trig_pin = touch;
  assign dir1 = DIR1;
  assign dir2 = DIR2;
endmodule
`default_nettype wire
